// File: rtl/lco_pkg.sv
// package: register map, image layout and timing for the link options block
package lco_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] OFF_ISO = 12'h800;
  localparam logic [11:0] OFF_ASY = 12'h808;
  localparam logic [11:0] OFF_LINK = 12'h840;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ISO = 32'h0000_7373;
  localparam logic [31:0] RST_ASY = 32'h0010_7373;
  localparam logic [31:0] RST_LINK = 32'h0000_0020;
  // ==========================================================
  // link control word fields
  localparam int POST_LSB = 3;
  localparam int POST_MSB = 5;
  localparam int CYC_LSB = 0;
  localparam int CYC_MSB = 2;
  localparam logic [2:0] POST_MAX = 3'h4;
  localparam logic [2:0] CYC_SEL_MAX = 3'h4;
  // ==========================================================
  // image byte addresses
  localparam logic [7:0] IMG_SSVID_LO = 8'h00;
  localparam logic [7:0] IMG_SSVID_HI = 8'h01;
  localparam logic [7:0] IMG_SSID_LO = 8'h02;
  localparam logic [7:0] IMG_SSID_HI = 8'h03;
  localparam logic [7:0] IMG_MIN_GNT = 8'h04;
  localparam logic [7:0] IMG_MAX_LAT = 8'h05;
  localparam logic [7:0] IMG_SWAP = 8'h07;
  localparam logic [7:0] IMG_WORD_FIRST = 8'h08;
  localparam logic [7:0] IMG_SYS_SPACE = 8'h24;
  localparam logic [2:0] WRD_ISO = 3'h0;
  localparam logic [2:0] WRD_ASY = 3'h1;
  localparam logic [2:0] WRD_LINK = 3'h2;
  localparam logic [2:0] WRD_BUSOPT = 3'h3;
  localparam logic [2:0] WRD_GUID_HI = 3'h4;
  localparam logic [2:0] WRD_GUID_LO = 3'h5;
  localparam logic [2:0] WRD_ROM_HDR = 3'h6;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CYC_PERIOD_PS = 125000000;
  localparam int CYC_BASE_CYCLES = CYC_PERIOD_PS / CLK_PERIOD_PS;
  // ==========================================================
  // image fields handed to the rest of the chip
  typedef struct packed {
    logic [15:0] ssvid;
    logic [15:0] ssid;
    logic [7:0] min_gnt;
    logic [7:0] max_lat;
    logic swap;
    logic [31:0] bus_opt;
    logic [31:0] guid_hi;
    logic [31:0] guid_lo;
    logic [31:0] rom_hdr;
  } lco_image_t;
  typedef enum logic [0:0] {LD_WAIT, LD_DONE} lco_ld_state_t;
endpackage : lco_pkg

// File: rtl/lco_top.sv
// link options register, configuration image loader and root cycle timer
// Notes on behaviour
// - link control word is a read/write register at offset 0x840.
// - bits 5:3 limit queued physical posted writes; reset and maximum is four.
// - a posted-write limit above four disables all physical posted writes.
// - bits 2:0 pick the cycle period, used only while this node is root.
// - select 0..4 gives 125, 62.5, 31.25, 15.625, 7.81 us; halving each step, the last (1562 cycles) rounded down.
// - image bytes 0x00/0x01 hold subsystem vendor id low/high byte.
// - image bytes 0x02/0x03 hold subsystem id low/high byte.
// - byte 0x04 min grant, 0x05 max latency, 0x06 ignored.
// - bit 0 of image byte 0x07 is the global byte-swap control.
// - image bytes from 0x24 up are system space, not loader fields.
// - with an image present, dma and link words load from it; else defaults.
`timescale 1ns/1ps
module lco_top #(
  parameter int CYC_BASE = lco_pkg::CYC_BASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reg_sel,
  input wire logic reg_we,
  input wire logic [11:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_ff,
  output logic reg_ack_ff,
  input wire logic img_present,
  input wire logic img_valid,
  input wire logic [7:0] img_addr,
  input wire logic [7:0] img_data,
  input wire logic img_last,
  input wire logic root_node,
  output logic loaded_ff,
  output lco_pkg::lco_image_t img_cfg_ff,
  output logic [31:0] iso_dma_ff,
  output logic [31:0] asy_dma_ff,
  output logic [31:0] link_ff,
  output logic posted_ok_ff,
  output logic cycle_tick_ff
);
  // ==========================================================
  // helpers
  function automatic logic [31:0] put_lane(input logic [31:0] w, input logic [7:0] b,
                                           input logic [1:0] lane);
    logic [31:0] r;
    r = w;
    r[lane*8 +: 8] = b;
    return r;
  endfunction : put_lane

  function automatic logic [31:0] put_be(input logic [31:0] w, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : put_be

  function automatic logic [14:0] period_of(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > lco_pkg::CYC_SEL_MAX) ? 3'h0 : sel;
    return 15'(CYC_BASE >> s);
  endfunction : period_of

  // ==========================================================
  // register bus and image loader
  lco_pkg::lco_ld_state_t st_ff, nxt_st;
  logic [31:0] nxt_iso, nxt_asy, nxt_link, nxt_rdata;
  logic nxt_ack, nxt_loaded;
  lco_pkg::lco_image_t nxt_img;
  logic take_byte;
  logic [7:0] rel;
  logic [2:0] wrd;
  logic [1:0] lane;

  always_comb begin
    nxt_st = st_ff;
    nxt_iso = iso_dma_ff;
    nxt_asy = asy_dma_ff;
    nxt_link = link_ff;
    nxt_img = img_cfg_ff;
    nxt_rdata = 32'h0000_0000;
    nxt_ack = 1'b0;
    nxt_loaded = loaded_ff;
    take_byte = img_valid && img_present && (st_ff == lco_pkg::LD_WAIT);
    rel = img_addr - lco_pkg::IMG_WORD_FIRST;
    wrd = rel[4:2];
    lane = img_addr[1:0];
    if (take_byte) begin
      case (img_addr)
        lco_pkg::IMG_SSVID_LO: nxt_img.ssvid[7:0] = img_data;
        lco_pkg::IMG_SSVID_HI: nxt_img.ssvid[15:8] = img_data;
        lco_pkg::IMG_SSID_LO: nxt_img.ssid[7:0] = img_data;
        lco_pkg::IMG_SSID_HI: nxt_img.ssid[15:8] = img_data;
        lco_pkg::IMG_MIN_GNT: nxt_img.min_gnt = img_data;
        lco_pkg::IMG_MAX_LAT: nxt_img.max_lat = img_data;
        lco_pkg::IMG_SWAP: nxt_img.swap = img_data[0];
        default: begin
          if (img_addr >= lco_pkg::IMG_WORD_FIRST && img_addr < lco_pkg::IMG_SYS_SPACE) begin
            case (wrd)
              lco_pkg::WRD_ISO: nxt_iso = put_lane(iso_dma_ff, img_data, lane);
              lco_pkg::WRD_ASY: nxt_asy = put_lane(asy_dma_ff, img_data, lane);
              lco_pkg::WRD_LINK: nxt_link = put_lane(link_ff, img_data, lane);
              lco_pkg::WRD_BUSOPT: nxt_img.bus_opt = put_lane(img_cfg_ff.bus_opt, img_data, lane);
              lco_pkg::WRD_GUID_HI: nxt_img.guid_hi = put_lane(img_cfg_ff.guid_hi, img_data, lane);
              lco_pkg::WRD_GUID_LO: nxt_img.guid_lo = put_lane(img_cfg_ff.guid_lo, img_data, lane);
              lco_pkg::WRD_ROM_HDR: nxt_img.rom_hdr = put_lane(img_cfg_ff.rom_hdr, img_data, lane);
              default: nxt_img = img_cfg_ff;
            endcase
          end
          // bytes 0x06 and from 0x24 up fall through untouched
        end
      endcase
    end
    case (st_ff)
      lco_pkg::LD_WAIT: begin
        if (!img_present || (img_valid && img_last)) begin
          nxt_st = lco_pkg::LD_DONE;
          nxt_loaded = 1'b1;
        end
      end
      lco_pkg::LD_DONE: nxt_st = lco_pkg::LD_DONE;
      default: nxt_st = lco_pkg::LD_WAIT;
    endcase
    // bus access; a write in the same cycle as an image byte wins
    if (reg_sel) begin
      nxt_ack = 1'b1;
      case (reg_addr)
        lco_pkg::OFF_ISO: begin
          nxt_rdata = iso_dma_ff;
          if (reg_we) begin
            nxt_iso = put_be(iso_dma_ff, reg_wdata, reg_be);
          end
        end
        lco_pkg::OFF_ASY: begin
          nxt_rdata = asy_dma_ff;
          if (reg_we) begin
            nxt_asy = put_be(asy_dma_ff, reg_wdata, reg_be);
          end
        end
        lco_pkg::OFF_LINK: begin
          nxt_rdata = link_ff;
          if (reg_we) begin
            nxt_link = put_be(link_ff, reg_wdata, reg_be);
          end
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
      if (reg_we) begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= lco_pkg::LD_WAIT;
      iso_dma_ff <= lco_pkg::RST_ISO;
      asy_dma_ff <= lco_pkg::RST_ASY;
      link_ff <= lco_pkg::RST_LINK;
      img_cfg_ff <= '0;
      reg_rdata_ff <= 32'h0000_0000;
      reg_ack_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      iso_dma_ff <= nxt_iso;
      asy_dma_ff <= nxt_asy;
      link_ff <= nxt_link;
      img_cfg_ff <= nxt_img;
      reg_rdata_ff <= nxt_rdata;
      reg_ack_ff <= nxt_ack;
      loaded_ff <= nxt_loaded;
    end
  end

  // ==========================================================
  // posted-write gate and root cycle timer
  logic [14:0] cyc_cnt_ff, nxt_cyc_cnt;
  logic nxt_tick, nxt_posted_ok;

  always_comb begin
    nxt_posted_ok = (link_ff[lco_pkg::POST_MSB:lco_pkg::POST_LSB] <= lco_pkg::POST_MAX);
    nxt_tick = 1'b0;
    nxt_cyc_cnt = cyc_cnt_ff;
    if (!root_node) begin
      nxt_cyc_cnt = 15'h0000;
    end else if (cyc_cnt_ff == 15'h0000) begin
      nxt_tick = 1'b1;
      nxt_cyc_cnt = period_of(link_ff[lco_pkg::CYC_MSB:lco_pkg::CYC_LSB]) - 15'h0001;
    end else begin
      nxt_cyc_cnt = cyc_cnt_ff - 15'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cyc_cnt_ff <= 15'h0000;
      cycle_tick_ff <= 1'b0;
      posted_ok_ff <= 1'b1;
    end else begin
      cyc_cnt_ff <= nxt_cyc_cnt;
      cycle_tick_ff <= nxt_tick;
      posted_ok_ff <= nxt_posted_ok;
    end
  end

  // ==========================================================
  // assertions
  logic bus_wr;
  assign bus_wr = reg_sel && reg_we;

  property p_link_read;
    @(posedge core_clk) disable iff (reset)
    (reg_sel && !reg_we && reg_addr == lco_pkg::OFF_LINK)
      |=> reg_ack_ff && reg_rdata_ff == $past(link_ff);
  endproperty
  a_link_read: assert property (p_link_read) else $error("link word read mismatch");

  property p_post_reset;
    @(posedge core_clk) disable iff (reset)
    $fell(reset) |-> link_ff[5:3] == 3'h4 && link_ff[2:0] == 3'h0;
  endproperty
  a_post_reset: assert property (p_post_reset) else $error("link word reset value wrong");

  property p_post_gate;
    @(posedge core_clk) disable iff (reset)
    posted_ok_ff == ($past(link_ff[5:3]) <= 3'h4);
  endproperty
  a_post_gate: assert property (p_post_gate) else $error("posted write gate wrong");

  property p_no_tick_off_root;
    @(posedge core_clk) disable iff (reset)
    !root_node |=> !cycle_tick_ff;
  endproperty
  a_no_tick_off_root: assert property (p_no_tick_off_root) else $error("tick off root");

  property p_period_load;
    @(posedge core_clk) disable iff (reset)
    (root_node && cyc_cnt_ff == 15'h0000) |=> cycle_tick_ff
      && cyc_cnt_ff == period_of($past(link_ff[2:0])) - 15'h0001;
  endproperty
  a_period_load: assert property (p_period_load) else $error("cycle period reload wrong");

  property p_ssvid_hi;
    @(posedge core_clk) disable iff (reset)
    (take_byte && img_addr == 8'h01) |=> img_cfg_ff.ssvid[15:8] == $past(img_data);
  endproperty
  a_ssvid_hi: assert property (p_ssvid_hi) else $error("vendor id high byte wrong");

  property p_ssid_lo;
    @(posedge core_clk) disable iff (reset)
    (take_byte && img_addr == 8'h02) |=> img_cfg_ff.ssid[7:0] == $past(img_data);
  endproperty
  a_ssid_lo: assert property (p_ssid_lo) else $error("subsystem id low byte wrong");

  property p_max_lat;
    @(posedge core_clk) disable iff (reset)
    (take_byte && img_addr == 8'h05) |=> img_cfg_ff.max_lat == $past(img_data);
  endproperty
  a_max_lat: assert property (p_max_lat) else $error("max latency wrong");

  property p_swap;
    @(posedge core_clk) disable iff (reset)
    (take_byte && img_addr == 8'h07) |=> img_cfg_ff.swap == $past(img_data[0]);
  endproperty
  a_swap: assert property (p_swap) else $error("byte swap bit wrong");

  property p_sys_space;
    @(posedge core_clk) disable iff (reset)
    (take_byte && img_addr >= 8'h24 && !bus_wr) |=> $stable(link_ff) && $stable(img_cfg_ff);
  endproperty
  a_sys_space: assert property (p_sys_space) else $error("system space byte used");

  property p_link_lane;
    @(posedge core_clk) disable iff (reset)
    (take_byte && img_addr == 8'h11 && !bus_wr) |=> link_ff[15:8] == $past(img_data);
  endproperty
  a_link_lane: assert property (p_link_lane) else $error("link word lane wrong");

  property p_absent;
    @(posedge core_clk) disable iff (reset)
    (img_valid && !img_present && !bus_wr) |=> $stable(iso_dma_ff) && $stable(link_ff);
  endproperty
  a_absent: assert property (p_absent) else $error("load without image");
endmodule : lco_top

// File: sim/lco_eeprom_model.sv
// image source model: streams the configuration image byte by byte
`timescale 1ns/1ps
module lco_eeprom_model (
  input wire logic core_clk,
  input wire logic start,
  input wire logic [3:0] gap,
  output logic img_valid,
  output logic [7:0] img_addr,
  output logic [7:0] img_data,
  output logic img_last
);
  // ==========================================================
  // byte stream, idle lines keep changing between bytes
  initial begin
    img_valid = 1'b0;
    img_addr = 8'h00;
    img_data = 8'h00;
    img_last = 1'b0;
    forever begin
      @(posedge core_clk);
      if (start) begin
        for (int a = 0; a < 40; a++) begin
          img_valid <= 1'b1;
          img_addr <= 8'(a);
          img_data <= 8'(a) + 8'h22;
          img_last <= (a == 39);
          for (int g = 0; g < gap; g++) begin
            @(posedge core_clk);
            img_valid <= 1'b0;
            img_last <= 1'b0;
            img_data <= ~img_data;
            img_addr <= img_addr + 8'h01;
          end
          @(posedge core_clk);
        end
        img_valid <= 1'b0;
        img_last <= 1'b0;
      end
    end
  end
endmodule : lco_eeprom_model

// File: sim/link_options_and_eeprom_image_test.sv
// self-checking bench for the link options register and image loader
`timescale 1ns/1ps
module link_options_and_eeprom_image_test;
  logic core_clk, reset, reg_sel, reg_we, img_present, img_valid, img_last, root_node;
  logic [11:0] reg_addr;
  logic [3:0] reg_be, gap;
  logic [31:0] reg_wdata, reg_rdata_ff, iso_dma_ff, asy_dma_ff, link_ff, rd;
  logic [7:0] img_addr, img_data;
  logic reg_ack_ff, loaded_ff, posted_ok_ff, cycle_tick_ff, start;
  lco_pkg::lco_image_t img_cfg_ff;
  int failures = 0;
  int cmp_count = 0;
  lco_top #(.CYC_BASE(32)) dut (.core_clk(core_clk), .reset(reset), .reg_sel(reg_sel),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff), .img_present(img_present),
    .img_valid(img_valid), .img_addr(img_addr), .img_data(img_data), .img_last(img_last),
    .root_node(root_node), .loaded_ff(loaded_ff), .img_cfg_ff(img_cfg_ff),
    .iso_dma_ff(iso_dma_ff), .asy_dma_ff(asy_dma_ff), .link_ff(link_ff),
    .posted_ok_ff(posted_ok_ff), .cycle_tick_ff(cycle_tick_ff));
  lco_eeprom_model partner (.core_clk(core_clk), .start(start), .gap(gap),
    .img_valid(img_valid), .img_addr(img_addr), .img_data(img_data), .img_last(img_last));
  // ==========================================================
  // helpers
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] word_at(input logic [7:0] a);
    return {a + 8'h25, a + 8'h24, a + 8'h23, a + 8'h22};
  endfunction : word_at
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic do_reset(input logic pres);
    @(posedge core_clk);
    reset <= 1'b1;
    img_present <= pres;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
  endtask : do_reset
  task automatic reg_io(input logic we, input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] wd);
    @(posedge core_clk);
    reg_sel <= 1'b1;
    reg_we <= we;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= wd;
    @(posedge core_clk);
    reg_sel <= 1'b0;
    #1;
    chk("ack", 32'h1, {31'h0, reg_ack_ff});
    rd = reg_rdata_ff;
  endtask : reg_io
  task automatic wait_sig(input string what, ref logic s, input int bound, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (s !== 1'b1 && n < bound);
    if (s !== 1'b1) begin
      $display("[FAIL] %s expected 1 seen %b", what, s);
      failures++;
      wrap_up();
    end
  endtask : wait_sig
  // ==========================================================
  // scenarios
  task automatic t_no_image;
    int n;
    do_reset(1'b0);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    wait_sig("loaded", loaded_ff, 8, n);
    repeat (50) @(posedge core_clk);
    reg_io(1'b0, lco_pkg::OFF_LINK, 4'hf, 32'h0);
    chk("link reset", lco_pkg::RST_LINK, rd);
    reg_io(1'b0, lco_pkg::OFF_ISO, 4'hf, 32'h0);
    chk("iso reset", lco_pkg::RST_ISO, rd);
    reg_io(1'b0, lco_pkg::OFF_ASY, 4'hf, 32'h0);
    chk("asy reset", lco_pkg::RST_ASY, rd);
    chk("posted ok", 32'h1, {31'h0, posted_ok_ff});
  endtask : t_no_image
  task automatic t_load;
    int n;
    do_reset(1'b1);
    gap <= 4'h3;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    wait_sig("loaded", loaded_ff, 400, n);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ssvid", {16'h0, 8'h23, 8'h22}, {16'h0, img_cfg_ff.ssvid});
    chk("ssid", {16'h0, 8'h25, 8'h24}, {16'h0, img_cfg_ff.ssid});
    chk("grant latency", 32'h2726, {16'h0, img_cfg_ff.max_lat, img_cfg_ff.min_gnt});
    chk("swap", 32'h1, {31'h0, img_cfg_ff.swap});
    chk("iso", word_at(8'h08), iso_dma_ff);
    chk("asy", word_at(8'h0c), asy_dma_ff);
    chk("link", word_at(8'h10), link_ff);
    chk("bus options", word_at(8'h14), img_cfg_ff.bus_opt);
    chk("guid hi", word_at(8'h18), img_cfg_ff.guid_hi);
    chk("guid lo", word_at(8'h1c), img_cfg_ff.guid_lo);
    chk("rom header", word_at(8'h20), img_cfg_ff.rom_hdr);
    chk("posted off", 32'h0, {31'h0, posted_ok_ff});
    reg_io(1'b1, lco_pkg::OFF_ISO, 4'hf, 32'h1234_5678);
    reg_io(1'b1, lco_pkg::OFF_ASY, 4'h1, 32'hffff_ff99);
    @(posedge core_clk);
    gap <= 4'h0;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (50) @(posedge core_clk);
    reg_io(1'b0, lco_pkg::OFF_ISO, 4'hf, 32'h0);
    chk("iso after late bytes", 32'h1234_5678, rd);
    reg_io(1'b0, lco_pkg::OFF_ASY, 4'hf, 32'h0);
    chk("asy byte write", 32'h3130_2f99, rd);
  endtask : t_load
  task automatic t_regs;
    reg_io(1'b1, lco_pkg::OFF_LINK, 4'hf, 32'h0000_0020);
    reg_io(1'b1, 12'h844, 4'hf, 32'hffff_ffff);
    reg_io(1'b0, 12'h844, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("posted at four", 32'h1, {31'h0, posted_ok_ff});
    reg_io(1'b1, lco_pkg::OFF_LINK, 4'hf, 32'h0000_0028);
    reg_io(1'b1, lco_pkg::OFF_LINK, 4'h2, 32'hffff_ff00);
    chk("posted at five", 32'h0, {31'h0, posted_ok_ff});
    reg_io(1'b0, lco_pkg::OFF_LINK, 4'hf, 32'h0);
    chk("byte enable", 32'h0000_ff28, rd);
  endtask : t_regs
  task automatic t_cycle;
    int n;
    for (int s = 0; s < 6; s++) begin
      reg_io(1'b1, lco_pkg::OFF_LINK, 4'hf, 32'h20 | s);
      @(posedge core_clk);
      root_node <= 1'b1;
      wait_sig("first tick", cycle_tick_ff, 4, n);
      wait_sig("tick", cycle_tick_ff, 64, n);
      chk("period", (s > 4) ? 32 : (32 >> s), n);
      @(posedge core_clk);
      root_node <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      #1;
      chk("no tick off root", 32'h0, {31'h0, cycle_tick_ff});
    end
    reg_io(1'b1, lco_pkg::OFF_LINK, 4'hf, lco_pkg::RST_LINK);
  endtask : t_cycle
  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    reg_sel = 1'b0;
    reg_we = 1'b0;
    reg_addr = 12'h000;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
    img_present = 1'b0;
    root_node = 1'b0;
    start = 1'b0;
    gap = 4'h0;
    t_no_image();
    t_load();
    t_regs();
    t_cycle();
    wrap_up();
  end
endmodule : link_options_and_eeprom_image_test
